// ---- rtl/serial_nand_status_otp_regs.sv ----
`timescale 1ns/1ps
`include "nand_status_defines.svh"

// Functional notes
// - program fail on failure or protected target
// - program execute or reset clears program fail
// - erase fail on failure, protected target or one-time region
// - block erase start or reset clears erase fail
// - write enable sets latch, disable clears it
// - busy while program, read, erase, reset run
// - drive field defaults 00, survives soft reset
// - drive codes give 100/75/50/25 percent
// - protect status powers up 1, reset keeps
// - status byte read at feature C0
// - drive register set/get at feature D0
// - ecc main/extended codes report corrected counts
// - main ecc 10 when errors exceed eight
// - ten one-time pages 02 to 0B, sequential
// - one-time enable redirects array accesses
// - both bits plus execute lock region forever
// - locked region read only, never erased
// - ecc covers one-time data when enabled
// - ecc status cleared at reset/read start
// - C0/F0 read only, others read/write
// - lock bit nonvolatile, rest volatile
module serial_nand_status_otp_regs
   import nand_status_pkg::*;
(
   input wire logic mclk,
   input wire logic reset,
   input wire logic sclk,
   input wire logic csN,
   input wire logic si,
   output logic so,
   output logic soOe,
   output logic arrayReq,
   output logic [1:0] arrayOp,
   output logic [23:0] arrayRow,
   output logic arrayOtp,
   output logic arrayEccOn,
   input wire logic arrayDone,
   input wire logic arrayFail,
   input wire logic [3:0] arrayErrCount,
   input wire logic rowProtected,
   input wire logic otpLockStored,
   output logic otpLockBurn,
   output logic [1:0] driveStrengthSel,
   output logic [6:0] drivePercent
);

   // ---------------- link side, on the serial clock ----------------
   logic [5:0] bitCnt;
   logic [6:0] shiftIn;
   logic [7:0] curByte;
   logic [7:0] opcode;
   logic [7:0] featAddr;
   logic [7:0] outShift;
   logic [7:0] readBack;
   logic [7:0] evOp;
   logic [23:0] evAddr;
   logic [7:0] evData;
   logic evToggle;

   // core snapshots, frozen while a frame is open
   logic [7:0] snapProtect;
   logic [7:0] snapFeature;
   logic [7:0] snapStatus;
   logic [7:0] snapDrive;
   logic [7:0] snapStatus2;

   assign curByte = {shiftIn, si};

   // bit position within the frame, cleared by the frame's own select
   always_ff @(posedge sclk or posedge csN) begin
      if (csN) begin
         bitCnt <= 6'h00;
      end else if (bitCnt != 6'h3F) begin
         bitCnt <= bitCnt + 6'h01;
      end
   end

   // input shifter, mode 0 sampling on the rising edge
   always_ff @(posedge sclk) begin
      shiftIn <= curByte[6:0];
   end

   // opcode and feature address capture
   always_ff @(posedge sclk) begin
      if (bitCnt == 6'h07) begin
         opcode <= curByte;
      end
      if (bitCnt == 6'h0F) begin
         featAddr <= curByte;
      end
   end

   // command words handed to the core; held until the next frame overwrites them, toggling or not
   always_ff @(posedge sclk) begin
      if (bitCnt == 6'h07) begin
         evOp <= curByte;
      end
      if (bitCnt == 6'h0F) begin
         evAddr[23:16] <= curByte;
         evAddr[7:0] <= curByte;
      end
      if (bitCnt == 6'h17) begin
         evAddr[15:8] <= curByte;
         evData <= curByte;
      end
      if (bitCnt == 6'h1F) begin
         evAddr[7:0] <= curByte;
      end
   end

   // event toggle; the only link flop that needs a known start
   always_ff @(posedge sclk or posedge reset) begin
      if (reset) begin
         evToggle <= 1'b0;
      end else if (bitCnt == 6'h07 && (curByte == OP_WREN || curByte == OP_WRDI
            || curByte == OP_SRESET)) begin
         evToggle <= ~evToggle;
      end else if (bitCnt == 6'h17 && opcode == OP_SETF) begin
         evToggle <= ~evToggle;
      end else if (bitCnt == 6'h1F && (opcode == OP_PEXEC || opcode == OP_PREAD
            || opcode == OP_BERASE)) begin
         evToggle <= ~evToggle;
      end
   end

   // readback select; snapshots are quasi-static during the frame
   always_comb begin
      case (featAddr)
         `FA_PROTECT: readBack = snapProtect;
         `FA_FEATURE: readBack = snapFeature;
         `FA_STATUS: readBack = snapStatus;
         `FA_DRIVE: readBack = snapDrive;
         `FA_STATUS2: readBack = snapStatus2;
         default: readBack = 8'h00;
      endcase
   end

   // output shifter on the falling edge; byte repeats until select rises
   always_ff @(negedge sclk or posedge csN) begin
      if (csN) begin
         so <= 1'b0;
         soOe <= 1'b0;
         outShift <= 8'h00;
      end else if (bitCnt == 6'h10 && opcode == OP_GETF) begin
         so <= readBack[7];
         soOe <= 1'b1;
         outShift <= {readBack[6:0], readBack[7]};
      end else if (soOe) begin
         so <= outShift[7];
         outShift <= {outShift[6:0], outShift[7]};
      end
   end

   // ---------------- core side, on mclk ----------------
   logic togSync1, togSync2, togSync3;
   logic csSync1, csSync2;
   logic cmdNew;
   core_state_t state;
   logic [1:0] pendOp;
   logic [7:0] rstCnt;
   logic busy;
   logic write_enable_latch;
   logic pFail;
   logic eFail;
   logic [1:0] eccMain;
   logic [1:0] eccExt;
   logic protection_state_status;
   logic [7:0] protect;
   logic eccEn;
   logic bpl;
   logic qe;
   logic otpEn;
   logic otpPrtReq;
   logic otpLock;
   logic lockLoad;
   logic [7:0] otpNext;
   logic [7:0] otpPage;
   logic otpPageBad;
   logic lockSeq;
   logic progBlocked;
   logic eraseBlocked;

   // toggle and select synchronisers; third toggle stage detects the edge
   always_ff @(posedge mclk) begin
      if (reset) begin
         togSync1 <= 1'b0;
         togSync2 <= 1'b0;
         togSync3 <= 1'b0;
         csSync1 <= 1'b1;
         csSync2 <= 1'b1;
      end else begin
         togSync1 <= evToggle;
         togSync2 <= togSync1;
         togSync3 <= togSync2;
         csSync1 <= csN;
         csSync2 <= csSync1;
      end
   end

   assign cmdNew = togSync2 ^ togSync3;

   // one-time region checks for the pending row
   assign otpPage = arrayRow[7:0];
   assign otpPageBad = otpPage < `OTP_FIRST_PAGE || otpPage > `OTP_LAST_PAGE
      || otpPage < otpNext;
   assign lockSeq = otpEn & otpPrtReq & ~otpLock;
   assign progBlocked = otpEn ? (otpLock | otpPageBad) : rowProtected;
   assign eraseBlocked = otpEn | rowProtected;

   // sequencer; soft reset is taken in any state and drops the array op
   always_ff @(posedge mclk) begin
      if (reset) begin
         state <= ST_IDLE;
         pendOp <= AOP_READ;
         rstCnt <= 8'h00;
      end else if (cmdNew && evOp == OP_SRESET) begin
         state <= ST_RESET;
         rstCnt <= 8'(`RESET_BUSY_CYC - 1);
      end else begin
         case (state)
            ST_IDLE: begin
               if (cmdNew && evOp == OP_PEXEC) begin
                  state <= ST_CHECK;
                  pendOp <= AOP_PROGRAM;
               end else if (cmdNew && evOp == OP_BERASE) begin
                  state <= ST_CHECK;
                  pendOp <= AOP_ERASE;
               end else if (cmdNew && evOp == OP_PREAD) begin
                  state <= ST_CHECK;
                  pendOp <= AOP_READ;
               end
            end
            ST_CHECK: begin
               // ops refused here never raise busy
               if (pendOp == AOP_READ) begin
                  state <= ST_ARRAY;
               end else if (!write_enable_latch || lockSeq) begin
                  state <= ST_IDLE;
               end else if (pendOp == AOP_PROGRAM && progBlocked) begin
                  state <= ST_IDLE;
               end else if (pendOp == AOP_ERASE && eraseBlocked) begin
                  state <= ST_IDLE;
               end else begin
                  state <= ST_ARRAY;
               end
            end
            ST_ARRAY: begin
               if (arrayDone) begin
                  state <= ST_IDLE;
               end
            end
            ST_RESET: begin
               if (rstCnt == 8'h00) begin
                  state <= ST_IDLE;
               end else begin
                  rstCnt <= rstCnt - 8'h01;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // busy follows the next state so it rises with the request
   always_ff @(posedge mclk) begin
      if (reset) begin
         busy <= 1'b0;
      end else if (cmdNew && evOp == OP_SRESET) begin
         busy <= 1'b1;
      end else if (state == ST_CHECK) begin
         busy <= pendOp == AOP_READ || (write_enable_latch && !lockSeq
            && !(pendOp == AOP_PROGRAM && progBlocked)
            && !(pendOp == AOP_ERASE && eraseBlocked));
      end else if (state == ST_ARRAY && arrayDone) begin
         busy <= 1'b0;
      end else if (state == ST_RESET && rstCnt == 8'h00) begin
         busy <= 1'b0;
      end
   end

   // array request, row and target region
   always_ff @(posedge mclk) begin
      if (reset) begin
         arrayReq <= 1'b0;
         arrayOp <= AOP_READ;
         arrayRow <= 24'h000000;
         arrayOtp <= 1'b0;
         arrayEccOn <= `ECC_EN_RESET;
      end else begin
         arrayReq <= 1'b0;
         if (state == ST_IDLE && cmdNew && (evOp == OP_PEXEC || evOp == OP_BERASE
               || evOp == OP_PREAD)) begin
            arrayRow <= evAddr;
         end
         if (state == ST_CHECK && !(cmdNew && evOp == OP_SRESET)) begin
            arrayOp <= pendOp;
            arrayOtp <= otpEn;
            arrayEccOn <= eccEn;
            arrayReq <= pendOp == AOP_READ || (write_enable_latch && !lockSeq
               && !(pendOp == AOP_PROGRAM && progBlocked)
               && !(pendOp == AOP_ERASE && eraseBlocked));
         end
      end
   end

   // write enable latch
   always_ff @(posedge mclk) begin
      if (reset) begin
         write_enable_latch <= 1'b0;
      end else if (cmdNew && (evOp == OP_WRDI || evOp == OP_SRESET)) begin
         write_enable_latch <= 1'b0;
      end else if (cmdNew && evOp == OP_WREN && state == ST_IDLE) begin
         write_enable_latch <= 1'b1;
      end else if (state == ST_CHECK && pendOp != AOP_READ && write_enable_latch) begin
         write_enable_latch <= 1'b0;
      end
   end

   // program fail: completion failure wins over the clear
   always_ff @(posedge mclk) begin
      if (reset) begin
         pFail <= 1'b0;
      end else if (state == ST_ARRAY && arrayDone && arrayFail && arrayOp == AOP_PROGRAM) begin
         pFail <= 1'b1;
      end else if (state == ST_CHECK && pendOp == AOP_PROGRAM && write_enable_latch && !lockSeq
            && progBlocked) begin
         pFail <= 1'b1;
      end else if (cmdNew && (evOp == OP_SRESET || (evOp == OP_PEXEC && state == ST_IDLE))) begin
         pFail <= 1'b0;
      end
   end

   // erase fail
   always_ff @(posedge mclk) begin
      if (reset) begin
         eFail <= 1'b0;
      end else if (state == ST_ARRAY && arrayDone && arrayFail && arrayOp == AOP_ERASE) begin
         eFail <= 1'b1;
      end else if (state == ST_CHECK && pendOp == AOP_ERASE && write_enable_latch && eraseBlocked) begin
         eFail <= 1'b1;
      end else if (cmdNew && (evOp == OP_SRESET || (evOp == OP_BERASE && state == ST_IDLE))) begin
         eFail <= 1'b0;
      end
   end

   // ecc status; left at 00 when ecc is off since it would be meaningless
   always_ff @(posedge mclk) begin
      if (reset) begin
         eccMain <= 2'b00;
         eccExt <= 2'b00;
      end else if (cmdNew && (evOp == OP_SRESET || (evOp == OP_PREAD && state == ST_IDLE))) begin
         eccMain <= 2'b00;
         eccExt <= 2'b00;
      end else if (state == ST_ARRAY && arrayDone && arrayOp == AOP_READ && arrayEccOn) begin
         if (arrayErrCount == 4'h0) begin
            eccMain <= 2'b00;
            eccExt <= 2'b00;
         end else if (arrayErrCount <= 4'h4) begin
            eccMain <= 2'b01;
            eccExt <= 2'b00;
         end else if (arrayErrCount < `ECC_CAPABILITY) begin
            eccMain <= 2'b01;
            eccExt <= 2'(arrayErrCount - 4'h4);
         end else if (arrayErrCount == `ECC_CAPABILITY) begin
            eccMain <= 2'b11;
            eccExt <= 2'b00;
         end else begin
            eccMain <= 2'b10;
            eccExt <= 2'b00;
         end
      end
   end

   // protection status of the last selected block; soft reset keeps it
   always_ff @(posedge mclk) begin
      if (reset) begin
         protection_state_status <= `BPS_RESET;
      end else if (state == ST_CHECK) begin
         protection_state_status <= rowProtected;
      end
   end

   // writable features; status addresses ignore writes
   always_ff @(posedge mclk) begin
      if (reset) begin
         protect <= `PROTECT_RESET;
         eccEn <= `ECC_EN_RESET;
         bpl <= 1'b0;
         qe <= 1'b0;
         otpEn <= 1'b0;
         otpPrtReq <= 1'b0;
         driveStrengthSel <= `DRIVE_RESET;
      end else if (cmdNew && evOp == OP_SETF) begin
         case (evAddr[7:0])
            `FA_PROTECT: begin
               if (!bpl) begin
                  protect <= evData & `PROTECT_MASK;
               end
            end
            `FA_FEATURE: begin
               otpPrtReq <= evData[`FT_LOCK_BIT];
               otpEn <= evData[`FT_OTPEN_BIT];
               eccEn <= evData[`FT_ECCEN_BIT];
               bpl <= bpl | evData[`FT_BPL_BIT];
               qe <= evData[`FT_QE_BIT];
            end
            `FA_DRIVE: driveStrengthSel <= evData[`DRV_HI:`DRV_LO];
            default: driveStrengthSel <= driveStrengthSel;
         endcase
      end
   end

   // drive percentage seen by the pad trim
   always_ff @(posedge mclk) begin
      if (reset) begin
         drivePercent <= 7'h64;
      end else begin
         case (driveStrengthSel)
            2'b00: drivePercent <= 7'h64;
            2'b01: drivePercent <= 7'h4B;
            2'b10: drivePercent <= 7'h32;
            default: drivePercent <= 7'h19;
         endcase
      end
   end

   // one-time lock: loaded from storage after reset, only ever goes to 1
   always_ff @(posedge mclk) begin
      if (reset) begin
         otpLock <= 1'b0;
         lockLoad <= 1'b1;
         otpLockBurn <= 1'b0;
         otpNext <= `OTP_FIRST_PAGE;
      end else begin
         lockLoad <= 1'b0;
         otpLockBurn <= 1'b0;
         if (lockLoad) begin
            otpLock <= otpLockStored;
         end else if (state == ST_CHECK && pendOp == AOP_PROGRAM && write_enable_latch && lockSeq) begin
            otpLock <= 1'b1;
            otpLockBurn <= 1'b1;
         end
         if (state == ST_ARRAY && arrayDone && !arrayFail && arrayOp == AOP_PROGRAM
               && arrayOtp) begin
            otpNext <= otpPage + 8'h01;
         end
      end
   end

   // snapshots refresh only between frames so the link reads stable bytes
   always_ff @(posedge mclk) begin
      if (reset) begin
         snapProtect <= `PROTECT_RESET;
         snapFeature <= 8'h10;
         snapStatus <= 8'h00;
         snapDrive <= 8'h00;
         snapStatus2 <= 8'h08;
      end else if (csSync2) begin
         snapProtect <= protect;
         snapFeature <= {otpLock | otpPrtReq, otpEn, 1'b0, eccEn, bpl, 2'b00, qe};
         snapStatus <= {2'b00, eccMain, pFail, eFail, write_enable_latch, busy};
         snapDrive <= {1'b0, driveStrengthSel, 5'b00000};
         snapStatus2 <= {2'b00, eccExt, protection_state_status, 3'b000};
      end
   end

endmodule // serial_nand_status_otp_regs

// ---- rtl/nand_status_defines.svh ----
`ifndef NAND_STATUS_DEFINES_SVH
`define NAND_STATUS_DEFINES_SVH

// feature addresses
`define FA_PROTECT 8'hA0
`define FA_FEATURE 8'hB0
`define FA_STATUS 8'hC0
`define FA_DRIVE 8'hD0
`define FA_STATUS2 8'hF0

// operation_status bit positions
`define ST_BUSY_BIT 0
`define ST_WEL_BIT 1
`define ST_EFAIL_BIT 2
`define ST_PFAIL_BIT 3
`define ST_ECC_LO 4
`define ST_ECC_HI 5

// feature register bit positions
`define FT_LOCK_BIT 7
`define FT_OTPEN_BIT 6
`define FT_ECCEN_BIT 4
`define FT_BPL_BIT 3
`define FT_QE_BIT 0

// writable bit masks, reserved bits stay low
`define PROTECT_MASK 8'hBE
`define FEATURE_MASK 8'hD9

// drive field and protection_state_status positions
`define DRV_LO 5
`define DRV_HI 6
`define F0_BPS_BIT 3
`define F0_EXT_LO 4
`define F0_EXT_HI 5

// power-up values
`define PROTECT_RESET 8'h38
`define DRIVE_RESET 2'h0
`define ECC_EN_RESET 1'b1
`define BPS_RESET 1'b1

// one-time region page window
`define OTP_FIRST_PAGE 8'h02
`define OTP_LAST_PAGE 8'h0B

// ecc thresholds
`define ECC_CAPABILITY 4'h8

// soft reset busy time
`define CLK_PERIOD_NS 4
`define RESET_BUSY_NS 500
`define RESET_BUSY_CYC ((`RESET_BUSY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ---- rtl/nand_status_pkg.sv ----
package nand_status_pkg;

   typedef enum logic [7:0] {
      OP_WREN = 8'h06,
      OP_WRDI = 8'h04,
      OP_GETF = 8'h0F,
      OP_SETF = 8'h1F,
      OP_PEXEC = 8'h10,
      OP_PREAD = 8'h13,
      OP_BERASE = 8'hD8,
      OP_SRESET = 8'hFF
   } opcode_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_CHECK = 2'b01,
      ST_ARRAY = 2'b10,
      ST_RESET = 2'b11
   } core_state_t;

   typedef enum logic [1:0] {
      AOP_READ = 2'b00,
      AOP_PROGRAM = 2'b01,
      AOP_ERASE = 2'b10
   } array_op_t;

endpackage

// ---- test/serial_nand_status_otp_regs_sva.sv ----
`timescale 1ns/1ps
// port-level checks of the status block, core clock only
module serial_nand_status_otp_regs_sva
   import nand_status_pkg::*;
(
   input wire logic mclk,
   input wire logic reset,
   input wire logic csN,
   input wire logic soOe,
   input wire logic arrayReq,
   input wire logic [1:0] arrayOp,
   input wire logic [23:0] arrayRow,
   input wire logic arrayOtp,
   input wire logic arrayEccOn,
   input wire logic otpLockBurn,
   input wire logic [1:0] driveStrengthSel,
   input wire logic [6:0] drivePercent
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);

   // percent falls by 25 per code step
   function automatic logic [6:0] pct(input logic [1:0] c);
      return 7'h64 - 7'h19 * c;
   endfunction

   // two quiet cycles allow a registered percent to follow the code
   sequence s_steady;
      $stable(driveStrengthSel) ##1 $stable(driveStrengthSel);
   endsequence
   sequence s_deselected;
      csN ##1 csN;
   endsequence

   AST_DRV_MAP: assert property (s_steady |-> drivePercent == pct(driveStrengthSel))
      else $error("drive percent does not match code");
   AST_DRV_RST: assert property ($fell(reset) |-> driveStrengthSel == 2'h0 && arrayEccOn)
      else $error("power-up drive or ecc value wrong");
   AST_REQ_PULSE: assert property (arrayReq |=> !arrayReq)
      else $error("array request longer than one cycle");
   AST_OP_LEGAL: assert property (arrayReq |-> arrayOp != 2'h3)
      else $error("array request with unknown operation");
   AST_BURN_PULSE: assert property (otpLockBurn |=> !otpLockBurn [*2])
      else $error("lock burn not a single pulse");
   AST_BURN_NOOP: assert property (otpLockBurn |-> !arrayReq)
      else $error("lock burn started an array operation");
   AST_OTP_NO_ERASE: assert property (arrayReq && arrayOtp |-> arrayOp != AOP_ERASE)
      else $error("erase issued into one-time region");
   AST_ROW_HELD: assert property (arrayReq |-> $stable(arrayRow))
      else $error("row changed at request");
   AST_SO_IDLE: assert property (s_deselected |-> !soOe)
      else $error("data out driven while deselected");
endmodule // serial_nand_status_otp_regs_sva

bind serial_nand_status_otp_regs serial_nand_status_otp_regs_sva u_sva (
   .mclk(mclk),
   .reset(reset),
   .csN(csN),
   .soOe(soOe),
   .arrayReq(arrayReq),
   .arrayOp(arrayOp),
   .arrayRow(arrayRow),
   .arrayOtp(arrayOtp),
   .arrayEccOn(arrayEccOn),
   .otpLockBurn(otpLockBurn),
   .driveStrengthSel(driveStrengthSel),
   .drivePercent(drivePercent)
);

// ---- test/spi_host.sv ----
`timescale 1ns/1ps
// host end of the serial link; clock only runs inside frames
module spi_host (
   output logic sclk,
   output logic csN,
   output logic si,
   input wire logic so
);
   initial begin
      sclk = 1'b0;
      si = 1'b0;
      #1 csN = 1'b1; // rising select clears the frame logic at start
   end

   // mode 0: data set while clock low, captured on the rise
   task automatic frame(input logic [31:0] d, input int n, output logic [7:0] rd);
      rd = 8'h00;
      #7.3 csN = 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         si = d[i];
         #24 sclk = 1'b1;
         rd = {rd[6:0], so};
         #24 sclk = 1'b0;
      end
      #11 csN = 1'b1;
      si = ~si; // released line must not look held
      #40; // gap lets the status snapshot refresh
   endtask
endmodule // spi_host

// ---- test/serial_nand_status_otp_regs_tb.sv ----
`timescale 1ns/1ps
`include "nand_status_defines.svh"
module serial_nand_status_otp_regs_tb;
   import nand_status_pkg::*;
   logic mclk, reset, sclk, csN, si, so, soOe, arrayReq, arrayOtp, arrayEccOn;
   logic arrayDone, arrayFail, rowProtected, otpLockBurn, failNext, lastOtp, lastEcc, lockStored;
   logic [1:0] arrayOp, driveStrengthSel;
   logic [23:0] arrayRow, lastRow;
   logic [3:0] arrayErrCount, errNext;
   logic [6:0] drivePercent;
   logic [7:0] rd;
   logic [7:0] pct [4] = '{8'h64, 8'h4B, 8'h32, 8'h19};
   int n_mismatch, num_checks, cyc, reqN, doneN, burnN;

   serial_nand_status_otp_regs DUT (.mclk(mclk), .reset(reset), .sclk(sclk), .csN(csN),
      .si(si), .so(so), .soOe(soOe), .arrayReq(arrayReq), .arrayOp(arrayOp),
      .arrayRow(arrayRow), .arrayOtp(arrayOtp), .arrayEccOn(arrayEccOn),
      .arrayDone(arrayDone), .arrayFail(arrayFail), .arrayErrCount(arrayErrCount),
      .rowProtected(rowProtected), .otpLockStored(lockStored), .otpLockBurn(otpLockBurn),
      .driveStrengthSel(driveStrengthSel), .drivePercent(drivePercent));
   spi_host host (.sclk(sclk), .csN(csN), .si(si), .so(so));

   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end

   // array stand-in: answers each request 400 cycles later
   always @(posedge mclk) begin
      if (otpLockBurn === 1'b1) burnN++;
      if (arrayReq === 1'b1) begin
         reqN++;
         lastOtp = arrayOtp;
         lastEcc = arrayEccOn;
         lastRow = arrayRow;
         // host never programs or erases block 3F, the block it treats as bad
         if (arrayOp != AOP_READ)
            check("bad block", {7'h0, arrayRow[23:6] == 18'h0003F}, 8'h00);
         fork
            begin
               repeat (400) @(posedge mclk);
               #1 arrayDone = 1'b1;
               arrayFail = failNext;
               arrayErrCount = errNext;
               @(posedge mclk);
               #1 arrayDone = 1'b0;
               doneN++;
            end
         join_none
      end
   end

   // hang guard
   always @(posedge mclk) begin
      cyc++;
      if (cyc > 80000) begin
         n_mismatch++;
         conclude();
      end
   end

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic op8(input logic [7:0] op);
      host.frame({24'h0, op}, 8, rd);
   endtask
   task automatic setf(input logic [7:0] a, input logic [7:0] v);
      host.frame({8'h00, OP_SETF, a, v}, 24, rd);
   endtask
   task automatic getf(input logic [7:0] a);
      host.frame({8'h00, OP_GETF, a, 8'h00}, 24, rd);
   endtask
   // waits out any array operation still open
   task automatic settle();
      for (int i = 0; i < 3000 && doneN != reqN; i++) @(posedge mclk);
      repeat (8) @(posedge mclk);
   endtask
   task automatic sreset();
      op8(OP_SRESET);
      repeat (140) @(posedge mclk); // busy lasts 125 cycles
   endtask
   // write enable, array command, then status low nibble
   task automatic wop(input logic [7:0] op, input logic [23:0] row, input logic f);
      failNext = f;
      op8(OP_WREN);
      host.frame({op, row}, 32, rd);
      settle();
      getf(`FA_STATUS);
   endtask

   task automatic t_reset();
      getf(`FA_STATUS);
      check("status", rd & 8'h0F, 8'h00);
      getf(`FA_STATUS2);
      check("bps", {7'h0, rd[3]}, 8'h01);
      getf(`FA_DRIVE);
      check("drive", rd, 8'h00);
   endtask

   task automatic t_drive();
      for (int c = 0; c < 4; c++) begin
         setf(`FA_DRIVE, 8'(c << 5));
         getf(`FA_DRIVE);
         check("drive", rd, 8'(c << 5));
         check("percent", {1'b0, drivePercent}, pct[c]);
      end
      sreset();
      getf(`FA_DRIVE);
      check("drive kept", rd, 8'h60);
      setf(`FA_STATUS, 8'hFF);
      getf(`FA_STATUS);
      check("status ro", rd & 8'h0F, 8'h00);
   endtask

   task automatic t_wel();
      op8(OP_WREN);
      getf(`FA_STATUS);
      check("wel set", rd & 8'h0F, 8'h02);
      op8(OP_WRDI);
      getf(`FA_STATUS);
      check("wel clear", rd & 8'h0F, 8'h00);
   endtask

   task automatic t_flags();
      failNext = 1'b1;
      op8(OP_WREN);
      host.frame({OP_PEXEC, 24'h000100}, 32, rd);
      getf(`FA_STATUS);
      check("busy", rd & 8'h0F, 8'h01);
      settle();
      getf(`FA_STATUS);
      check("pfail", rd & 8'h0F, 8'h08);
      wop(OP_PEXEC, 24'h000140, 1'b0);
      check("pfail clr", rd & 8'h0F, 8'h00);
      rowProtected = 1'b1;
      wop(OP_PEXEC, 24'h000180, 1'b0);
      check("prot prog", rd & 8'h0F, 8'h08);
      wop(OP_BERASE, 24'h000180, 1'b0);
      check("prot erase", rd & 8'h0F, 8'h0C);
      sreset();
      getf(`FA_STATUS);
      check("reset clr", rd & 8'h0F, 8'h00);
      rowProtected = 1'b0;
      wop(OP_BERASE, 24'h000200, 1'b1);
      check("efail", rd & 8'h0F, 8'h04);
      wop(OP_BERASE, 24'h000240, 1'b0);
      check("efail clr", rd & 8'h0F, 8'h00);
      host.frame({OP_PEXEC, 24'h000240}, 32, rd);
      settle();
      check("no wel drop", 8'(reqN), 8'h04);
   endtask

   task automatic t_ecc();
      logic [3:0] e;
      logic [1:0] m;
      for (int k = 0; k < 7; k++) begin
         e = (k == 0) ? 4'h0 : 4'(k + 3);
         m = (e == 0) ? 2'h0 : (e <= 7) ? 2'h1 : (e == 8) ? 2'h3 : 2'h2;
         errNext = e;
         host.frame({OP_PREAD, 24'h000300}, 32, rd);
         settle();
         check("ecc on", {7'h0, lastEcc}, 8'h01);
         getf(`FA_STATUS);
         check("ecc main", {6'h0, rd[5:4]}, {6'h0, m});
         getf(`FA_STATUS2);
         if (m == 2'h1)
            check("ecc ext", {6'h0, rd[5:4]}, 8'(e > 4 ? e - 4 : 0));
      end
      sreset();
      getf(`FA_STATUS);
      check("ecc clr", {6'h0, rd[5:4]}, 8'h00);
   endtask

   task automatic t_otp();
      setf(`FA_FEATURE, 8'h50);
      wop(OP_PEXEC, 24'h000002, 1'b0);
      check("otp target", {7'h0, lastOtp}, 8'h01);
      check("otp row", lastRow[7:0], 8'h02);
      check("otp ok", rd & 8'h0F, 8'h00);
      wop(OP_BERASE, 24'h000003, 1'b0);
      check("otp erase", rd & 8'h0F, 8'h04);
      wop(OP_PEXEC, 24'h000001, 1'b0);
      check("otp order", {7'h0, rd[3]}, 8'h01);
      setf(`FA_FEATURE, 8'hD0);
      wop(OP_PEXEC, 24'h000000, 1'b0);
      check("burn", 8'(burnN), 8'h01);
      getf(`FA_FEATURE);
      check("lock bit", {7'h0, rd[7]}, 8'h01);
      sreset();
      wop(OP_PEXEC, 24'h000004, 1'b0);
      check("locked prog", {7'h0, rd[3]}, 8'h01);
   endtask

   // power cycle with the lock already stored: region is read only
   task automatic t_power();
      lockStored = 1'b1;
      @(posedge mclk);
      #1 reset = 1'b1;
      repeat (5) @(posedge mclk);
      #1 reset = 1'b0;
      repeat (4) @(posedge mclk);
      getf(`FA_DRIVE);
      check("drive power", rd, 8'h00);
      setf(`FA_FEATURE, 8'h50);
      getf(`FA_FEATURE);
      check("lock stored", rd, 8'hD0);
      wop(OP_PEXEC, 24'h000002, 1'b0);
      check("stored lock prog", {7'h0, rd[3]}, 8'h01);
      check("no burn", 8'(burnN), 8'h01);
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   initial begin
      rowProtected = 1'b0;
      lockStored = 1'b0;
      arrayDone = 1'b0;
      arrayFail = 1'b0;
      arrayErrCount = 4'h0;
      failNext = 1'b0;
      errNext = 4'h0;
      #1 reset = 1'b1; // late rise gives the link toggle its async clear
      repeat (5) @(posedge mclk);
      #1 reset = 1'b0;
      repeat (4) @(posedge mclk);
      t_reset();
      t_drive();
      t_wel();
      t_flags();
      t_ecc();
      t_otp();
      t_power();
      conclude();
   end
endmodule // serial_nand_status_otp_regs_tb
